// file: src/sadm_bus_port.sv
// Split-address mux host bus port with APB register access
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Async read data 96 ns after valid rise
// - Lone low half reuses latched upper half
// - Sync mode: upper with OE low first
// - Sync cycles capture on link clock rise
// - Valid may stay low across both phases
// - Sensing starts on low half capture
// - Write commits on write-enable rise only
// - Write phase needs no link clock
// - Sync bursts from 9.6 to 104 MHz
// - Wait polarity and timing from config
// - Wordline crossing may add wait states
// - Split mode bit, upper cleared on entry
// - Valid rise: OE low upper, high lower
// - Wait driven exactly with data bus
module sadm_bus_port
  import sadm_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Host pins
  input  wire logic        link_clk,
  input  wire logic        address_valid_n,
  input  wire logic        chip_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic [15:0] adq_in,
  output var  logic [15:0] adq_out,
  output var  logic        adq_oe,
  output var  logic        wait_out,
  output var  logic        wait_oe
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  sadm_pins_if p ();

  sadm_pin_sync u_sync (
    .pclk            (pclk),
    .presetn         (presetn),
    .address_valid_n (address_valid_n),
    .chip_enable_n   (chip_enable_n),
    .output_enable_n (output_enable_n),
    .write_enable_n  (write_enable_n),
    .link_clk        (link_clk),
    .adq_in          (adq_in),
    .pins            (p.sync)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] cfg;
  logic [15:0] rdata;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] wdata;
  logic [31:0] waddr;
  logic        wdone;
  logic        rviol;
  logic        restarted;
  logic [3:0]  cnt;
  logic [3:0]  eol_cnt;
  logic        adv_q;
  logic        lclk_q;
  logic        we_q;
  sadm_state_e state;
  sadm_state_e next_state;

  // ----------------------------------------
  // Pin events
  // ----------------------------------------
  wire logic adv_rise  = p.address_valid_n & ~adv_q;
  wire logic lclk_rise = p.link_clk & ~lclk_q;
  wire logic we_rise   = p.write_enable_n & ~we_q;
  wire logic selected  = ~p.chip_enable_n;
  wire logic sync_mode = ~cfg[SADM_CFG_ASYNC_BIT];
  wire logic split     = cfg[SADM_CFG_SPLIT_BIT];
  wire logic no_wrap   = ~cfg[SADM_CFG_WRAP_BIT];

  // Sync capture samples while valid is low, async on its rise
  wire logic cap_strobe = selected & (sync_mode ? (lclk_rise & ~p.address_valid_n)
                                                : adv_rise);
  wire logic cap_upper  = cap_strobe & split & ~p.output_enable_n;
  wire logic cap_lower  = cap_strobe & p.output_enable_n;
  wire logic sensing    = (state == SADM_ST_SENSE);
  wire logic sense_done = sensing & (cnt == 4'h1);

  // Burst advance on each link clock rise in the data phase outside wordline wait states
  wire logic burst_step = sync_mode & selected & (state == SADM_ST_READY) & lclk_rise &
                          ~p.output_enable_n & p.address_valid_n & (eol_cnt == 4'h0);
  wire logic eol_hit    = burst_step & no_wrap & (lower[3:0] == SADM_WORDLINE_END);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic [7:0] ofs      = paddr[7:0];
  wire logic       hi_zero  = (paddr[31:8] == 24'h000000);
  wire logic hit_cfg   = hi_zero & (ofs == SADM_OFS_CFG);
  wire logic hit_rdata = hi_zero & (ofs == SADM_OFS_RDATA);
  wire logic hit_addr  = hi_zero & (ofs == SADM_OFS_ADDR);
  wire logic hit_wdata = hi_zero & (ofs == SADM_OFS_WDATA);
  wire logic hit_waddr = hi_zero & (ofs == SADM_OFS_WADDR);
  wire logic hit_stat  = hi_zero & (ofs == SADM_OFS_STAT);
  wire logic addr_hit  = hit_cfg | hit_rdata | hit_addr | hit_wdata | hit_waddr | hit_stat;
  wire logic wr_acc    = psel & penable & pwrite & addr_hit;
  wire logic rd_setup  = psel & ~penable & ~pwrite;
  wire logic wr_cfg    = wr_acc & hit_cfg;
  // Entry into split mode is the 0 to 1 change of the mode bit
  wire logic split_entry = wr_cfg & pwdata[SADM_CFG_SPLIT_BIT] & ~split;
  wire logic clr_wdone = wr_acc & hit_stat & pwdata[SADM_STAT_WDONE_BIT];
  wire logic clr_rviol = wr_acc & hit_stat & pwdata[SADM_STAT_RVIOL_BIT];

  wire logic [31:0] stat_word = {28'h0000000, split, rviol, wdone, sensing};
  wire logic [31:0] rd_mux =
      hit_cfg   ? {16'h0000, cfg}   :
      hit_rdata ? {16'h0000, rdata} :
      hit_addr  ? {upper, lower}    :
      hit_wdata ? {16'h0000, wdata} :
      hit_waddr ? waddr             :
      hit_stat  ? stat_word         : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // ----------------------------------------
  // Wait and drive
  // ----------------------------------------
  // Upper capture also has OE low, so no drive until a cycle is open
  wire logic drive = selected & ~p.output_enable_n & p.address_valid_n &
                     p.write_enable_n & (state != SADM_ST_IDLE);
  // Early mode drops wait one cycle before data turns valid
  wire logic wait_busy = cfg[SADM_CFG_WEARLY_BIT] ? (sensing & ~sense_done) : sensing;
  wire logic wait_act  = sync_mode & (wait_busy | (eol_cnt != 4'h0));
  wire logic wait_lvl  = cfg[SADM_CFG_WPOL_BIT] ? wait_act : ~wait_act;

  // ----------------------------------------
  // Cycle state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      SADM_ST_IDLE: begin
        if (cap_lower) begin
          next_state = SADM_ST_SENSE;
        end
      end
      SADM_ST_SENSE: begin
        if (sense_done) begin
          next_state = SADM_ST_READY;
        end
      end
      SADM_ST_READY: begin
        if (cap_lower) begin
          next_state = SADM_ST_SENSE;
        end else if (p.chip_enable_n) begin
          next_state = SADM_ST_IDLE;
        end
      end
      default: next_state = SADM_ST_IDLE;
    endcase
    // A fresh low half restarts sensing from any state
    if (cap_lower) begin
      next_state = SADM_ST_SENSE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= SADM_ST_IDLE;
      adv_q  <= 1'b1;
      lclk_q <= 1'b1;
      we_q   <= 1'b1;
    end else begin
      state  <= next_state;
      adv_q  <= p.address_valid_n;
      lclk_q <= p.link_clk;
      we_q   <= p.write_enable_n;
    end
  end

  // ----------------------------------------
  // Sense and wordline counters
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 4'h0;
      eol_cnt <= 4'h0;
    end else begin
      if (cap_lower) begin
        cnt <= SADM_SENSE_LOAD;
      end else if (sensing) begin
        cnt <= cnt - 4'h1;
      end
      if (eol_hit) begin
        eol_cnt <= SADM_EOL_LOAD;
      end else if (eol_cnt != 4'h0) begin
        eol_cnt <= eol_cnt - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Restart tracking
  // ----------------------------------------
  // Device tolerates a second restart but flags it for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restarted <= 1'b0;
      rviol     <= 1'b0;
    end else begin
      if (cap_lower & sensing) begin
        restarted <= 1'b1;
      end else if (sense_done) begin
        restarted <= 1'b0;
      end
      if (cap_lower & sensing & restarted) begin
        rviol <= 1'b1;
      end else if (clr_rviol) begin
        rviol <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Address halves
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper <= 16'h0000;
      lower <= 16'h0000;
    end else begin
      if (split_entry | ~split) begin
        upper <= 16'h0000;
      end else if (cap_upper) begin
        upper <= p.adq;
      end
      if (cap_lower) begin
        lower <= p.adq;
      end else if (burst_step) begin
        lower <= lower + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Write commit on write-enable rise, link clock unused
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata <= 16'h0000;
      waddr <= 32'h00000000;
      wdone <= 1'b0;
    end else begin
      if (we_rise & selected) begin
        wdata <= p.adq;
        waddr <= {upper, lower};
        wdone <= 1'b1;
      end else if (clr_wdone) begin
        wdone <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers and bus read data
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg    <= SADM_CFG_RESET;
      rdata  <= 16'h0000;
      prdata <= 32'h00000000;
    end else begin
      if (wr_cfg) begin
        cfg <= pwdata[15:0];
      end
      if (wr_acc & hit_rdata) begin
        rdata <= pwdata[15:0];
      end
      if (rd_setup) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adq_out  <= 16'h0000;
      adq_oe   <= 1'b0;
      wait_out <= 1'b1;
      wait_oe  <= 1'b0;
    end else begin
      adq_out  <= rdata;
      adq_oe   <= drive;
      wait_out <= wait_lvl;
      wait_oe  <= drive;
    end
  end

endmodule
`default_nettype wire

// file: src/sadm_pin_sync.sv
// Two-flop synchroniser for every host pin
`timescale 1ns/1ps
`default_nettype none
module sadm_pin_sync
  import sadm_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Raw pins
  input  wire logic        address_valid_n,
  input  wire logic        chip_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        link_clk,
  input  wire logic [15:0] adq_in,
  // Synchronised levels
  sadm_pins_if.sync        pins
);

  localparam int W = 21;

  wire  logic [W-1:0] raw;
  logic [W-1:0]       meta;
  logic [W-1:0]       stable;

  assign raw = {address_valid_n, chip_enable_n, output_enable_n,
                write_enable_n, link_clk, adq_in};

  // ----------------------------------------
  // Per-bit chain; strobes reset inactive high
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i]   <= (i >= 17) ? 1'b1 : 1'b0;
          stable[i] <= (i >= 17) ? 1'b1 : 1'b0;
        end else begin
          meta[i]   <= raw[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate

  assign pins.address_valid_n = stable[20];
  assign pins.chip_enable_n   = stable[19];
  assign pins.output_enable_n = stable[18];
  assign pins.write_enable_n  = stable[17];
  assign pins.link_clk        = stable[16];
  assign pins.adq             = stable[15:0];

endmodule
`default_nettype wire

// file: src/sadm_pins_if.sv
// Synchronised host pin levels passed from the synchroniser to the core
`timescale 1ns/1ps
`default_nettype none
interface sadm_pins_if;
  logic        address_valid_n;
  logic        chip_enable_n;
  logic        output_enable_n;
  logic        write_enable_n;
  logic        link_clk;
  logic [15:0] adq;

  modport sync (output address_valid_n, chip_enable_n, output_enable_n,
                output write_enable_n, link_clk, adq);
  modport core (input address_valid_n, chip_enable_n, output_enable_n,
                input write_enable_n, link_clk, adq);
endinterface
`default_nettype wire

// file: src/sadm_pkg.sv
// Constants and types shared by the split-address mux bus port
package sadm_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SADM_OFS_CFG   = 8'h00;
  localparam logic [7:0] SADM_OFS_RDATA = 8'h04;
  localparam logic [7:0] SADM_OFS_ADDR  = 8'h08;
  localparam logic [7:0] SADM_OFS_WDATA = 8'h0C;
  localparam logic [7:0] SADM_OFS_WADDR = 8'h10;
  localparam logic [7:0] SADM_OFS_STAT  = 8'h14;

  // ----------------------------------------
  // Configuration fields and reset value
  // ----------------------------------------
  localparam int          SADM_CFG_ASYNC_BIT  = 15;
  localparam int          SADM_CFG_WPOL_BIT   = 10;
  localparam int          SADM_CFG_WEARLY_BIT = 8;
  localparam int          SADM_CFG_SPLIT_BIT  = 4;
  localparam int          SADM_CFG_WRAP_BIT   = 3;
  localparam logic [15:0] SADM_CFG_RESET      = 16'h8000;

  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int SADM_STAT_BUSY_BIT  = 0;
  localparam int SADM_STAT_WDONE_BIT = 1;
  localparam int SADM_STAT_RVIOL_BIT = 2;
  localparam int SADM_STAT_SPLIT_BIT = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PCLK_PERIOD_NS         = 8;
  localparam int VALID_RISE_TO_DATA_NS  = 96;
  localparam int SADM_SYNC_LAT          = 4;
  localparam int SADM_SENSE_CYC         = VALID_RISE_TO_DATA_NS / PCLK_PERIOD_NS;
  localparam logic [3:0] SADM_SENSE_LOAD = 4'(SADM_SENSE_CYC - SADM_SYNC_LAT);
  localparam logic [3:0] SADM_EOL_LOAD   = 4'h8;
  localparam logic [3:0] SADM_WORDLINE_END = 4'hF;

  // ----------------------------------------
  // Cycle states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SADM_ST_IDLE  = 3'b001,
    SADM_ST_SENSE = 3'b010,
    SADM_ST_READY = 3'b100
  } sadm_state_e;

endpackage

// file: verification/sadm_bus_port_checker.sv
// Concurrent checks on the bus port's top-level pins
`timescale 1ns/1ps
`default_nettype none
module sadm_bus_port_checker
  import sadm_pkg::*;
(
  // Clock, reset and APB
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  // Host pins
  input wire logic        link_clk, address_valid_n, chip_enable_n, output_enable_n,
  input wire logic        write_enable_n, adq_oe, wait_out, wait_oe,
  input wire logic [15:0] adq_in, adq_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Shadow of software writes, idle counters
  // ----------------------------------------
  logic [15:0] cfg;
  logic [15:0] rdat;
  logic [3:0]  oe_hi;
  logic [3:0]  ce_hi;
  wire logic   acc = psel && penable;
  wire logic   ok  = paddr[31:8] == 24'h0;
  wire logic   wr  = acc && pwrite && ok;
  wire logic   rd  = acc && !pwrite && ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg   <= SADM_CFG_RESET;
      rdat  <= 16'h0;
      oe_hi <= 4'h0;
      ce_hi <= 4'h0;
    end else begin
      if (wr && paddr[7:0] == SADM_OFS_CFG) cfg <= pwdata[15:0];
      if (wr && paddr[7:0] == SADM_OFS_RDATA) rdat <= pwdata[15:0];
      // Saturate so a long idle never wraps back to zero
      oe_hi <= output_enable_n ? oe_hi + {3'h0, oe_hi != 4'hF} : 4'h0;
      ce_hi <= chip_enable_n ? ce_hi + {3'h0, ce_hi != 4'hF} : 4'h0;
    end
  end
  a_apb_zero_wait: assert property (acc |-> pready) else $error("pready low");
  a_slverr_unmapped: assert property (acc && !ok |-> pslverr) else $error("no slave error");
  a_slverr_mapped: assert property (rd && paddr[7:0] == SADM_OFS_STAT |-> !pslverr)
    else $error("slave error on mapped read");
  a_wait_with_data: assert property (wait_oe == adq_oe) else $error("wait enable split");
  a_oe_releases_bus: assert property (adq_oe |-> oe_hi < 4'h6)
    else $error("bus driven with output enable high");
  a_ce_releases_bus: assert property (adq_oe |-> ce_hi < 4'h6)
    else $error("bus driven while deselected");
  a_cfg_readback: assert property (rd && paddr[7:0] == SADM_OFS_CFG |->
    (prdata[15:0] & 16'h8518) == (cfg & 16'h8518)) else $error("config readback");
  a_upper_cleared: assert property (rd && paddr[7:0] == SADM_OFS_ADDR && !cfg[4] |->
    prdata[31:16] == 16'h0) else $error("upper half not zero");
  a_async_wait_idle: assert property (cfg[15] && wait_oe |-> wait_out == !cfg[10])
    else $error("async wait level");
  a_data_is_rdata: assert property (adq_oe && $stable(rdat) |-> adq_out == rdat)
    else $error("driven data differs");
endmodule
`default_nettype wire

// file: verification/sadm_host.sv
// Host memory controller model driving the split-address pins
`timescale 1ns/1ps
`default_nettype none
module sadm_host (
  // Clock
  input  wire logic        pclk,
  // Pins
  output var  logic        adv_n,
  output var  logic        ce_n,
  output var  logic        oe_n,
  output var  logic        we_n,
  output var  logic        lclk,
  output var  logic [15:0] adq
);
  // Pins idle: strobes inactive, link clock parked low
  initial begin
    adv_n = 1'b1;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    lclk = 1'b0;
    adq = 16'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Chip enable stays low between cycles
  task automatic aaddr(input logic oe, input logic [15:0] v);
    @(posedge pclk);
    ce_n <= 1'b0; oe_n <= oe; adv_n <= 1'b0; adq <= v;
    cyc(3);
    adv_n <= 1'b1;
    cyc(2);
    adq <= ~v;
  endtask
  task automatic set_oe(input logic v);
    @(posedge pclk);
    oe_n <= v;
  endtask
  // Link clock runs only in the address phases here and in lpulse burst steps
  task automatic saddr(input logic [15:0] u, l);
    @(posedge pclk);
    ce_n <= 1'b0; adv_n <= 1'b0; oe_n <= 1'b0; adq <= u;
    cyc(1); lclk <= 1'b1;
    cyc(4); lclk <= 1'b0; oe_n <= 1'b1; adq <= l;
    cyc(4); lclk <= 1'b1;
    cyc(4); lclk <= 1'b0; adv_n <= 1'b1; adq <= ~l;
  endtask
  // One 64 ns link clock period to step a burst
  task automatic lpulse();
    @(posedge pclk);
    lclk <= 1'b1;
    cyc(4);
    lclk <= 1'b0;
    cyc(3);
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge pclk);
    oe_n <= 1'b1; we_n <= 1'b0; adq <= d;
    cyc(5); we_n <= 1'b1;
    cyc(3); adq <= ~d;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_sadm_bus_port.sv
// Self-checking bench for the split-address mux bus port
`timescale 1ns/1ps
`default_nettype none
module tb_sadm_bus_port
  import sadm_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [23:0] hi = 24'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, adq_oe, wait_out, wait_oe, adv_n, ce_n, oe_n, we_n, lclk;
  logic [15:0] h_adq, adq_out, adq_w;
  int          err_total = 0;
  int          check_count = 0;
  integer      seed = 32'hCBBAC0A0;
  // Host owns the bus whenever it holds output enable high
  assign adq_w = (adq_oe && !oe_n) ? adq_out : h_adq;
  always #4 pclk = ~pclk;
  sadm_host u_sadm_host (.pclk(pclk), .adv_n(adv_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .lclk(lclk), .adq(h_adq));
  sadm_bus_port u_sadm_bus_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(lclk), .address_valid_n(adv_n),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n), .adq_in(adq_w),
    .adq_out(adq_out), .adq_oe(adq_oe), .wait_out(wait_out), .wait_oe(wait_oe));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {hi, a}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] up, lo, d;
    int          n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, SADM_OFS_CFG, 0, r, e); chk(r, {16'h0, SADM_CFG_RESET});
    apb(0, SADM_OFS_STAT, 0, r, e); chk(r, 32'h0);
    hi = 24'h1;
    apb(0, SADM_OFS_CFG, 0, r, e); chk({31'h0, e}, 32'h1); chk(r, 32'h0);
    hi = 24'h0;
    lo = 16'($random(seed));
    u_sadm_host.aaddr(1'b1, lo);
    u_sadm_host.cyc(12);
    apb(0, SADM_OFS_ADDR, 0, r, e); chk(r, {16'h0, lo});
    apb(1, SADM_OFS_CFG, 32'h8010, r, e);
    apb(0, SADM_OFS_ADDR, 0, r, e); chk({16'h0, r[31:16]}, 32'h0);
    apb(0, SADM_OFS_STAT, 0, r, e); chk({31'h0, r[3]}, 32'h1);
    $display("test boot and enable done");
    for (int i = 0; i < 4; i++) begin
      up = 16'($random(seed)); lo = 16'($random(seed)); d = 16'($random(seed));
      if (i == 0) up = 16'hFFFF;
      apb(1, SADM_OFS_RDATA, {16'h0, d}, r, e);
      u_sadm_host.aaddr(1'b0, up);
      u_sadm_host.aaddr(1'b1, lo);
      u_sadm_host.set_oe(1'b0);
      n = 2;
      while (adq_oe !== 1'b1 && n < 30) begin
        @(negedge pclk);
        n++;
      end
      chk({31'h0, n <= 12}, 32'h1); chk({16'h0, adq_out}, {16'h0, d});
      chk({31'h0, wait_oe}, 32'h1); chk({31'h0, wait_out}, 32'h1);
      u_sadm_host.set_oe(1'b1);
      apb(0, SADM_OFS_ADDR, 0, r, e); chk(r, {up, lo});
      lo = 16'($random(seed));
      u_sadm_host.aaddr(1'b1, lo);
      u_sadm_host.cyc(12);
      apb(0, SADM_OFS_ADDR, 0, r, e); chk(r, {up, lo});
    end
    $display("test async cycles done");
    d = 16'($random(seed));
    u_sadm_host.wr(d);
    apb(0, SADM_OFS_WDATA, 0, r, e); chk(r, {16'h0, d});
    apb(0, SADM_OFS_WADDR, 0, r, e); chk(r, {up, lo});
    for (int i = 0; i < 3; i++) u_sadm_host.aaddr(1'b1, lo);
    apb(0, SADM_OFS_STAT, 0, r, e); chk({29'h0, r[2:0]}, 32'h7);
    apb(1, SADM_OFS_STAT, 32'h6, r, e);
    apb(0, SADM_OFS_STAT, 0, r, e); chk({30'h0, r[2:1]}, 32'h0);
    $display("test write and restart done");
    for (int p = 0; p < 2; p++) begin
      apb(1, SADM_OFS_CFG, (p == 1) ? 32'h0418 : 32'h0018, r, e);
      up = 16'($random(seed)); lo = 16'($random(seed));
      u_sadm_host.saddr(up, lo);
      u_sadm_host.set_oe(1'b0);
      n = 0;
      while (wait_oe !== 1'b1 && n < 30) begin
        @(negedge pclk);
        n++;
      end
      chk({31'h0, wait_out}, p);
      repeat (14) @(negedge pclk);
      chk({31'h0, wait_out}, 32'(1 - p));
      u_sadm_host.set_oe(1'b1);
      apb(0, SADM_OFS_ADDR, 0, r, e); chk(r, {up, lo});
    end
    $display("test sync cycles done");
    // No-wrap burst crossing a wordline end adds wait states
    apb(1, SADM_OFS_CFG, 32'h0010, r, e);
    up = 16'($random(seed));
    lo = {12'($random(seed)), 4'hE};
    u_sadm_host.saddr(up, lo);
    u_sadm_host.set_oe(1'b0);
    repeat (16) @(negedge pclk);
    u_sadm_host.lpulse();
    u_sadm_host.lpulse();
    @(negedge pclk);
    chk({31'h0, wait_out}, 32'h0);
    repeat (8) @(negedge pclk);
    chk({31'h0, wait_out}, 32'h1);
    u_sadm_host.set_oe(1'b1);
    apb(0, SADM_OFS_ADDR, 0, r, e); chk(r, {up, lo + 16'h2});
    $display("test burst done");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule
bind sadm_bus_port sadm_bus_port_checker u_sadm_bus_port_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .link_clk(link_clk),
  .address_valid_n(address_valid_n), .chip_enable_n(chip_enable_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .adq_oe(adq_oe),
  .wait_out(wait_out), .wait_oe(wait_oe), .adq_in(adq_in), .adq_out(adq_out));
`default_nettype wire
